// file: logic/sbc_pkg.sv
`default_nettype none
package sbc_pkg;
  // Strap bit positions in the captured vector
  localparam int STRAP_COUNT = 5;
  localparam int BOOT_A_BIT = 0;
  localparam int BOOT_B_BIT = 1;
  localparam int SUPPLY_BIT = 2;
  localparam int PRINT_BIT = 3;
  localparam int EDGE_B_BIT = 4;
  // Values of undriven straps through the weak pulls
  localparam logic [4:0] STRAP_DEFAULT = 5'h19;
  // Fuse array layout
  localparam int FUSE_TOTAL_BITS = 1024;
  localparam int FUSE_SYSTEM_BITS = 256;
  localparam int FUSE_CUSTOMER_BITS = 768;
  localparam int FUSE_ADDR_W = 10;
  localparam logic [9:0] FUSE_DL_DISABLE_POS = 10'h000;
  localparam logic [9:0] FUSE_SUPPLY_OVR_POS = 10'h001;
  localparam logic [9:0] FUSE_SUPPLY_LVL_POS = 10'h002;
  localparam logic [9:0] FUSE_DEBUG_DIS_POS = 10'h003;
  localparam logic [9:0] FUSE_REV3_POS = 10'h004;
  // Strap hold time after reset release
  localparam int HOLD_TIME_MS = 1;
  localparam int CLOCK_MHZ = 200;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * 1000 * CLOCK_MHZ;
  // Boot modes
  typedef enum logic [1:0] {
    SBC_BOOT_FLASH,
    SBC_BOOT_DOWNLOAD,
    SBC_BOOT_BLOCKED,
    SBC_BOOT_INVALID
  } sbc_boot_type;
endpackage : sbc_pkg
`default_nettype wire

// file: logic/sbc_fuse_array.sv
`default_nettype none
module sbc_fuse_array #(
  parameter int BITS = sbc_pkg::FUSE_TOTAL_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic prog_en,
  input wire logic [sbc_pkg::FUSE_ADDR_W-1:0] prog_addr,
  output logic [BITS-1:0] fuse_bits
);
  initial begin
    if (BITS != sbc_pkg::FUSE_SYSTEM_BITS + sbc_pkg::FUSE_CUSTOMER_BITS) begin
      $error("fuse array size mismatch");
    end
  end
  // Cells cleared by reset: blank reads 0, a burn only ever sets
  genvar g;
  generate
    for (g = 0; g < BITS; g++) begin : g_cell
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          fuse_bits[g] <= 1'b0;
        end else if (prog_en && prog_addr == g) begin
          fuse_bits[g] <= 1'b1;
        end
      end
      burn_stays_a: assert property (@(posedge clk) disable iff (rst)
        $past(fuse_bits[g]) |-> fuse_bits[g]) else $error("fuse bit reverted");
    end
  endgenerate
endmodule : sbc_fuse_array
`default_nettype wire

// file: logic/sbc_strap_latch.sv
`default_nettype none
module sbc_strap_latch #(
  parameter int WIDTH = sbc_pkg::STRAP_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic capture,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_driven,
  input wire logic [WIDTH-1:0] pull_value,
  output logic [WIDTH-1:0] latched
);
  // Sample each strap once; nothing else can load the latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latched <= '0;
    end else if (capture) begin
      latched <= (pin_in & pin_driven) | (pull_value & ~pin_driven);
    end
  end
endmodule : sbc_strap_latch
`default_nettype wire

// file: logic/sbc_boot_config.sv
`default_nettype none
module sbc_boot_config #(
  parameter int HOLD_CYCLES = sbc_pkg::HOLD_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [4:0] STRAP_IN,
  input wire logic [4:0] STRAP_DRIVEN,
  input wire logic FUSE_PROG_EN,
  input wire logic [9:0] FUSE_PROG_ADDR,
  output logic CONFIG_VALID,
  output logic STRAPS_RELEASED,
  output logic [4:0] STRAP_LATCHED,
  output logic FLASH_BOOT,
  output logic DOWNLOAD_BOOT,
  output logic DOWNLOAD_BLOCKED,
  output logic BOOT_INVALID,
  output logic SUPPLY_SEL_1V8,
  output logic BOOT_PRINT_EN,
  output logic SDIO_SAMPLE_RISING,
  output logic SDIO_OUTPUT_RISING,
  output logic DEBUG_PORT_DISABLE,
  output logic [1023:0] FUSE_BITS
);
  initial begin
    if (HOLD_CYCLES < 1) begin
      $error("hold count must be at least one cycle");
    end
  end

  typedef enum {SBC_CAPTURE, SBC_HOLD, SBC_RUN} sbc_phase_type;
  sbc_phase_type phase_reg;
  logic [31:0] hold_cnt_reg;
  logic capture;
  logic [4:0] latched;
  logic [1023:0] fuse_bits;
  sbc_pkg::sbc_boot_type boot_next;
  logic supply_1v8_next;

  // Capture fires once, in the first cycle after reset release
  assign capture = (phase_reg == SBC_CAPTURE);

  sbc_strap_latch #(.WIDTH(sbc_pkg::STRAP_COUNT)) u_latch (
    .clk(MCLK),
    .rst(RST),
    .capture(capture),
    .pin_in(STRAP_IN),
    .pin_driven(STRAP_DRIVEN),
    .pull_value(sbc_pkg::STRAP_DEFAULT),
    .latched(latched)
  );

  sbc_fuse_array #(.BITS(sbc_pkg::FUSE_TOTAL_BITS)) u_fuse (
    .clk(MCLK),
    .rst(RST),
    .prog_en(FUSE_PROG_EN),
    .prog_addr(FUSE_PROG_ADDR),
    .fuse_bits(fuse_bits)
  );

  // Sequencer: capture, hold straps, then free pins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      phase_reg <= SBC_CAPTURE;
      hold_cnt_reg <= 32'h0;
    end else begin
      case (phase_reg)
        SBC_CAPTURE: begin
          phase_reg <= SBC_HOLD;
          hold_cnt_reg <= 32'h0;
        end
        SBC_HOLD: begin
          if (hold_cnt_reg == 32'(HOLD_CYCLES - 1)) begin
            phase_reg <= SBC_RUN;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
          end
        end
        default: begin
          phase_reg <= SBC_RUN;
        end
      endcase
    end
  end

  // Boot mode decode, purely combinational from latch and fuses
  always_comb begin
    boot_next = sbc_pkg::SBC_BOOT_INVALID;
    if (latched[sbc_pkg::BOOT_A_BIT]) begin
      boot_next = sbc_pkg::SBC_BOOT_FLASH;
    end else if (!latched[sbc_pkg::BOOT_B_BIT]) begin
      if (fuse_bits[sbc_pkg::FUSE_DL_DISABLE_POS] && fuse_bits[sbc_pkg::FUSE_REV3_POS]) begin
        boot_next = sbc_pkg::SBC_BOOT_BLOCKED;
      end else begin
        boot_next = sbc_pkg::SBC_BOOT_DOWNLOAD;
      end
    end
  end

  // Flash supply select: fuse override beats the strap
  always_comb begin
    if (fuse_bits[sbc_pkg::FUSE_SUPPLY_OVR_POS]) begin
      supply_1v8_next = !fuse_bits[sbc_pkg::FUSE_SUPPLY_LVL_POS];
    end else begin
      supply_1v8_next = latched[sbc_pkg::SUPPLY_BIT];
    end
  end

  // Registered configuration outputs, valid once capture has happened
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONFIG_VALID <= 1'b0;
      STRAPS_RELEASED <= 1'b0;
      STRAP_LATCHED <= 5'h00;
      FLASH_BOOT <= 1'b0;
      DOWNLOAD_BOOT <= 1'b0;
      DOWNLOAD_BLOCKED <= 1'b0;
      BOOT_INVALID <= 1'b0;
      SUPPLY_SEL_1V8 <= 1'b0;
      BOOT_PRINT_EN <= 1'b0;
      SDIO_SAMPLE_RISING <= 1'b0;
      SDIO_OUTPUT_RISING <= 1'b0;
      DEBUG_PORT_DISABLE <= 1'b0;
      FUSE_BITS <= '0;
    end else begin
      CONFIG_VALID <= (phase_reg != SBC_CAPTURE);
      STRAPS_RELEASED <= (phase_reg == SBC_RUN);
      STRAP_LATCHED <= latched;
      FLASH_BOOT <= (phase_reg != SBC_CAPTURE) && boot_next == sbc_pkg::SBC_BOOT_FLASH;
      DOWNLOAD_BOOT <= (phase_reg != SBC_CAPTURE) && boot_next == sbc_pkg::SBC_BOOT_DOWNLOAD;
      DOWNLOAD_BLOCKED <= (phase_reg != SBC_CAPTURE) && boot_next == sbc_pkg::SBC_BOOT_BLOCKED;
      BOOT_INVALID <= (phase_reg != SBC_CAPTURE) && boot_next == sbc_pkg::SBC_BOOT_INVALID;
      SUPPLY_SEL_1V8 <= (phase_reg != SBC_CAPTURE) && supply_1v8_next;
      BOOT_PRINT_EN <= (phase_reg != SBC_CAPTURE) && latched[sbc_pkg::PRINT_BIT];
      SDIO_SAMPLE_RISING <= (phase_reg != SBC_CAPTURE) && latched[sbc_pkg::PRINT_BIT];
      SDIO_OUTPUT_RISING <= (phase_reg != SBC_CAPTURE) && latched[sbc_pkg::EDGE_B_BIT];
      DEBUG_PORT_DISABLE <= fuse_bits[sbc_pkg::FUSE_DEBUG_DIS_POS];
      FUSE_BITS <= fuse_bits;
    end
  end

  // Checks
  sequence capture_done_s;
    phase_reg != SBC_CAPTURE;
  endsequence

  latch_frozen_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s |=> $stable(latched)) else $error("latched strap changed");
  flash_boot_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s and latched[0] |=> FLASH_BOOT) else $error("flash boot missed");
  download_boot_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s and latched[1:0] == 2'h0 && !(fuse_bits[0] && fuse_bits[4])
    |=> DOWNLOAD_BOOT) else $error("download boot missed");
  download_block_a: assert property (@(posedge MCLK) disable iff (RST)
    $past(fuse_bits[0] && fuse_bits[4]) |-> !DOWNLOAD_BOOT)
    else $error("download not blocked");
  invalid_combo_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s and latched[1:0] == 2'h2 |=> BOOT_INVALID && !FLASH_BOOT && !DOWNLOAD_BOOT)
    else $error("invalid straps not flagged");
  supply_strap_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s and !fuse_bits[1] |=> SUPPLY_SEL_1V8 == $past(latched[2]))
    else $error("supply strap decode wrong");
  supply_fuse_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s and fuse_bits[1] |=> SUPPLY_SEL_1V8 == !$past(fuse_bits[2]))
    else $error("supply fuse decode wrong");
  print_edge_a: assert property (@(posedge MCLK) disable iff (RST)
    capture_done_s |=> BOOT_PRINT_EN == $past(latched[3]) && SDIO_SAMPLE_RISING == BOOT_PRINT_EN
    && SDIO_OUTPUT_RISING == $past(latched[4])) else $error("print or edge decode wrong");
  debug_disable_a: assert property (@(posedge MCLK) disable iff (RST)
    fuse_bits[3] |=> DEBUG_PORT_DISABLE) else $error("debug port not disabled");
  release_time_a: assert property (@(posedge MCLK) disable iff (RST)
    $rose(STRAPS_RELEASED) |-> $past(CONFIG_VALID)) else $error("released before capture");
endmodule : sbc_boot_config
`default_nettype wire

// file: testbench/sbc_strap_board.sv
`default_nettype none
module sbc_strap_board (
  input wire logic clk,
  input wire logic released,
  input wire logic [4:0] level,
  input wire logic [4:0] mask,
  output logic [4:0] strap_in,
  output logic [4:0] strap_driven
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] io_reg;
  // Ordinary IO traffic toggles the pins once the straps are free
  always_ff @(posedge clk) begin
    io_reg <= released ? ~io_reg : level;
  end
  // Resistors or a host set the level; undriven pins show the opposite of the weak pull
  always_comb begin
    strap_in = released ? io_reg : ((level & mask) | (~sbc_pkg::STRAP_DEFAULT & ~mask));
    strap_driven = released ? 5'h1f : mask;
  end
endmodule : sbc_strap_board
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic FUSE_PROG_EN = 1'b0;
  logic [9:0] FUSE_PROG_ADDR = 10'h000;
  logic [4:0] level = 5'h00;
  logic [4:0] mask = 5'h00;
  logic [4:0] eff;
  logic [9:0] addr;
  logic [13:0] note;
  logic [13:0] notes[$];
  int n_mismatch = 0;
  int compares = 0;
  int seed;
  wire [4:0] STRAP_IN, STRAP_DRIVEN, STRAP_LATCHED;
  wire CONFIG_VALID, STRAPS_RELEASED, FLASH_BOOT, DOWNLOAD_BOOT, DOWNLOAD_BLOCKED, BOOT_INVALID;
  wire SUPPLY_SEL_1V8, BOOT_PRINT_EN, SDIO_SAMPLE_RISING, SDIO_OUTPUT_RISING, DEBUG_PORT_DISABLE;
  wire [1023:0] FUSE_BITS;
  wire [8:0] dec = {FLASH_BOOT, DOWNLOAD_BOOT, DOWNLOAD_BLOCKED, BOOT_INVALID, SUPPLY_SEL_1V8,
    BOOT_PRINT_EN, SDIO_SAMPLE_RISING, SDIO_OUTPUT_RISING, DEBUG_PORT_DISABLE};

  // 200 MHz clock
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end

  sbc_boot_config #(.HOLD_CYCLES(4)) i_sbc_boot_config (.MCLK(MCLK), .RST(RST),
    .STRAP_IN(STRAP_IN), .STRAP_DRIVEN(STRAP_DRIVEN), .FUSE_PROG_EN(FUSE_PROG_EN),
    .FUSE_PROG_ADDR(FUSE_PROG_ADDR), .CONFIG_VALID(CONFIG_VALID),
    .STRAPS_RELEASED(STRAPS_RELEASED), .STRAP_LATCHED(STRAP_LATCHED), .FLASH_BOOT(FLASH_BOOT),
    .DOWNLOAD_BOOT(DOWNLOAD_BOOT), .DOWNLOAD_BLOCKED(DOWNLOAD_BLOCKED),
    .BOOT_INVALID(BOOT_INVALID), .SUPPLY_SEL_1V8(SUPPLY_SEL_1V8), .BOOT_PRINT_EN(BOOT_PRINT_EN),
    .SDIO_SAMPLE_RISING(SDIO_SAMPLE_RISING), .SDIO_OUTPUT_RISING(SDIO_OUTPUT_RISING),
    .DEBUG_PORT_DISABLE(DEBUG_PORT_DISABLE), .FUSE_BITS(FUSE_BITS));

  sbc_strap_board i_sbc_strap_board (.clk(MCLK), .released(STRAPS_RELEASED), .level(level),
    .mask(mask), .strap_in(STRAP_IN), .strap_driven(STRAP_DRIVEN));

  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait on valid (sel 0) or release (sel 1)
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    while (k < 20 && (sel == 0 ? CONFIG_VALID : STRAPS_RELEASED) !== 1'b1) begin
      @(posedge MCLK);
      k++;
    end
    if (k == 20) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_hi

  // Oldest note is compared when a configuration appears
  initial begin
    forever begin
      @(posedge CONFIG_VALID);
      #1;
      note = notes.pop_front();
      check(16'(dec), 16'(note[8:0]));
      check(16'(STRAP_LATCHED), 16'(note[13:9]));
    end
  end

  // Power-up cycles over strap patterns, then pin activity and fuse burns
  initial begin
    seed = 32'h4296abb8;
    for (int i = 0; i < 16; i++) begin
      @(posedge MCLK);
      #1;
      RST = 1'b1;
      level = 5'($random(seed));
      mask = (i < 2) ? 5'(i * 31) : 5'($random(seed));
      if (i >= 2 && i < 6) begin
        level[1:0] = 2'(i - 2);
        mask[1:0] = 2'h3;
      end
      eff = (level & mask) | (sbc_pkg::STRAP_DEFAULT & ~mask);
      notes.push_back({eff, eff[0], ~eff[0] & ~eff[1], 1'b0, ~eff[0] & eff[1], eff[2],
        eff[3], eff[3], eff[4], 1'b0});
      repeat (6) @(posedge MCLK);
      #1;
      check(16'({CONFIG_VALID, dec}), 16'h0000);
      RST = 1'b0;
      wait_hi(0);
      wait_hi(1);
      repeat (3) @(posedge MCLK);
      #1;
      check(16'(STRAP_LATCHED), 16'(eff));
      addr = 10'(256 + ($unsigned($random(seed)) % 768));
      FUSE_PROG_EN = 1'b1;
      FUSE_PROG_ADDR = 10'h003;
      @(posedge MCLK);
      #1;
      FUSE_PROG_ADDR = addr;
      @(posedge MCLK);
      #1;
      FUSE_PROG_ADDR = 10'h003;
      @(posedge MCLK);
      #1;
      FUSE_PROG_EN = 1'b0;
      repeat (3) @(posedge MCLK);
      #1;
      check(16'({FUSE_BITS[3], FUSE_BITS[addr], DEBUG_PORT_DISABLE}), 16'h0007);
      check(16'($countones(FUSE_BITS)), 16'h0002);
      // Both boot straps low here: burn the download disable, revision and supply override fuses
      if (i == 2) begin
        FUSE_PROG_EN = 1'b1;
        FUSE_PROG_ADDR = 10'h000;
        @(posedge MCLK);
        #1;
        FUSE_PROG_ADDR = 10'h004;
        @(posedge MCLK);
        #1;
        FUSE_PROG_ADDR = 10'h001;
        @(posedge MCLK);
        #1;
        FUSE_PROG_EN = 1'b0;
        repeat (3) @(posedge MCLK);
        #1;
        check(16'({DOWNLOAD_BOOT, DOWNLOAD_BLOCKED, SUPPLY_SEL_1V8}), 16'h0003);
      end
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
